//--- logic/self_test_if.sv
// handshake between the command sequencer and the self-test unit
`timescale 1ns/1ps
`default_nettype none
interface self_test_if;
  logic start;
  logic busy;
  logic done;
  logic [2:0] result;
  modport ctrl (output start, input busy, input done, input result);
  modport unit (input start, output busy, output done, output result);
endinterface
`default_nettype wire

//--- logic/self_test_unit.sv
// timed self-test run that collects the three memory fault indications
`timescale 1ns/1ps
`default_nettype none
module self_test_unit
  import status_sync_pkg::*;
#(
  parameter int TEST_CYCLES = SELF_TEST_CYCLES
)(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_fault_program_mem,
  input wire logic i_fault_work_ram,
  input wire logic i_fault_nonvol_mem,
  self_test_if.unit st
);

  initial
  begin
    if (TEST_CYCLES < 1 || TEST_CYCLES > 65535)
      $error("self_test_unit: TEST_CYCLES out of range");
  end

  logic [15:0] count_r;
  logic busy_r;
  logic done_r;
  logic [2:0] result_r;
  logic last_cycle;
  logic [2:0] fault_vec;

  assign last_cycle = busy_r && (count_r == 16'h0001);
  assign fault_vec[TST_PROGRAM_MEM] = i_fault_program_mem;
  assign fault_vec[TST_WORK_RAM] = i_fault_work_ram;
  assign fault_vec[TST_NONVOL_MEM] = i_fault_nonvol_mem;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      count_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      result_r <= 3'h0;
    end
    else
    begin
      done_r <= last_cycle;
      if (st.start && !busy_r)
      begin
        busy_r <= 1'b1;
        count_r <= 16'(TEST_CYCLES);
      end
      else if (last_cycle)
      begin
        busy_r <= 1'b0;
        count_r <= 16'h0000;
        result_r <= fault_vec;
      end
      else if (busy_r)
        count_r <= count_r - 16'h0001;
    end
  end

  assign st.busy = busy_r;
  assign st.done = done_r;
  assign st.result = result_r;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  property p_result_from_faults;
    last_cycle |=> st.done && st.result == $past(fault_vec);
  endproperty
  a_result_from_faults: assert property (p_result_from_faults) else $error("result not faults");

  property p_clean_is_zero;
    last_cycle && fault_vec == 3'h0 |=> st.result == 3'h0;
  endproperty
  a_clean_is_zero: assert property (p_clean_is_zero) else $error("clean test not zero");

endmodule
`default_nettype wire

//--- logic/status_sync_commands.sv
// common self-test, synchronisation and status command interpreter
`timescale 1ns/1ps
`default_nettype none
module status_sync_commands
  import status_sync_pkg::*;
#(
  parameter int TEST_CYCLES = SELF_TEST_CYCLES
)(
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_link_gpib,
  input wire logic i_cmd_valid,
  input wire logic [3:0] i_cmd_code,
  input wire logic [7:0] i_cmd_arg,
  output logic o_cmd_ready,
  input wire logic i_prior_busy,
  output logic o_resp_valid,
  output logic [7:0] o_resp_data,
  output logic o_resp_text,
  input wire logic i_resp_ready,
  input wire logic [7:0] i_event_set,
  input wire logic [7:0] i_dev_event_zero,
  input wire logic [7:0] i_dev_event_one,
  input wire logic i_msg_available,
  input wire logic i_fault_program_mem,
  input wire logic i_fault_work_ram,
  input wire logic i_fault_nonvol_mem,
  output logic [7:0] o_event_status,
  output logic [7:0] o_status_byte,
  output logic o_clear_status
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_PRIOR = 2'b01,
    ST_TEST = 2'b10,
    ST_RESPOND = 2'b11
  } state_t;

  state_t state_r;
  state_t state_nxt;
  cmd_code_t code_r;
  cmd_code_t code_in;
  logic [7:0] event_status_latch_r;
  logic [7:0] event_status_latch_nxt;
  logic [7:0] event_enable_mask_r;
  logic [7:0] srq_enable_r;
  logic [7:0] device_event_status_zero_r;
  logic [7:0] device_event_status_one_r;
  logic resp_valid_r;
  logic [7:0] resp_data_r;
  logic resp_text_r;
  logic [7:0] status_byte_r;
  logic clear_status_r;

  self_test_if st();

  self_test_unit #(.TEST_CYCLES(TEST_CYCLES)) self_test_unit_i (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_fault_program_mem(i_fault_program_mem),
    .i_fault_work_ram(i_fault_work_ram),
    .i_fault_nonvol_mem(i_fault_nonvol_mem),
    .st(st)
  );

  wire logic take;
  wire logic is_known;
  wire logic do_clear;
  wire logic do_read_clear;
  wire logic prior_done;
  wire logic opc_fire;
  wire logic [7:0] link_mask;
  wire logic [7:0] set_vec;
  wire logic [7:0] set_gated;
  wire logic [7:0] stb_low;
  wire logic master_summary;
  wire logic [7:0] status_byte_now;
  wire logic [7:0] esr_read;

  assign code_in = cmd_code_t'(i_cmd_code);
  assign o_cmd_ready = (state_r == ST_IDLE);
  assign take = i_cmd_valid && o_cmd_ready;
  assign is_known = (i_cmd_code >= 4'h1) && (i_cmd_code <= 4'hB);
  assign do_clear = take && code_in == CMD_CLEAR_STATUS;
  assign do_read_clear = take && code_in == CMD_EVT_STATUS_Q;
  assign prior_done = (state_r == ST_WAIT_PRIOR) && !i_prior_busy;
  assign opc_fire = prior_done && code_r == CMD_OP_COMPLETE;

  // serial link hides user request, request control and operation complete
  assign link_mask = i_link_gpib ? 8'hFF : ~SERIAL_UNUSED_MASK;
  // an unknown code raises the command error flag
  assign set_vec = i_event_set
                 | {7'h00, opc_fire}
                 | ((take && !is_known) ? (8'h01 << BIT_COMMAND_ERROR) : 8'h00);
  assign set_gated = set_vec & link_mask;
  assign esr_read = event_status_latch_r & link_mask;

  // set wins over clear so an event in the clearing cycle is kept
  assign event_status_latch_nxt = ((do_clear || do_read_clear) ? 8'h00 : event_status_latch_r)
                                  | set_gated;

  assign stb_low[7:6] = 2'b00;
  assign stb_low[STB_EVENT_SUMMARY] = |(event_status_latch_r & event_enable_mask_r);
  assign stb_low[STB_MESSAGE_AVAIL] = i_msg_available;
  assign stb_low[3:2] = 2'b00;
  assign stb_low[STB_DEV_SUMMARY_ONE] = |device_event_status_one_r;
  assign stb_low[STB_DEV_SUMMARY_ZERO] = |device_event_status_zero_r;
  assign master_summary = |(stb_low & srq_enable_r);
  assign status_byte_now = stb_low | (master_summary ? (8'h01 << STB_MASTER_SUMMARY) : 8'h00);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          case (code_in)
            CMD_OP_COMPLETE, CMD_OP_COMPLETE_Q, CMD_WAIT: state_nxt = ST_WAIT_PRIOR;
            CMD_SELF_TEST_Q: state_nxt = ST_TEST;
            CMD_EVT_ENABLE_Q, CMD_EVT_STATUS_Q, CMD_SRQ_ENABLE_Q,
            CMD_STATUS_BYTE_Q: state_nxt = ST_RESPOND;
            default: state_nxt = ST_IDLE;
          endcase
        end
      end
      ST_WAIT_PRIOR:
      begin
        if (!i_prior_busy)
          state_nxt = (code_r == CMD_OP_COMPLETE_Q) ? ST_RESPOND : ST_IDLE;
      end
      ST_TEST:
      begin
        if (st.done)
          state_nxt = ST_RESPOND;
      end
      ST_RESPOND:
      begin
        if (i_resp_ready)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign st.start = take && code_in == CMD_SELF_TEST_Q;

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_r <= ST_IDLE;
      code_r <= CMD_NONE;
      event_status_latch_r <= EVT_STATUS_RESET;
      event_enable_mask_r <= EVT_ENABLE_RESET;
      srq_enable_r <= SRQ_ENABLE_RESET;
      device_event_status_zero_r <= 8'h00;
      device_event_status_one_r <= 8'h00;
      status_byte_r <= 8'h00;
      clear_status_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (take)
        code_r <= code_in;
      event_status_latch_r <= event_status_latch_nxt;
      if (take && code_in == CMD_EVT_ENABLE_W)
        event_enable_mask_r <= i_cmd_arg;
      if (take && code_in == CMD_SRQ_ENABLE_W)
        srq_enable_r <= i_cmd_arg & SRQ_WRITABLE_MASK;
      device_event_status_zero_r <= (do_clear ? 8'h00 : device_event_status_zero_r)
                                    | i_dev_event_zero;
      device_event_status_one_r <= (do_clear ? 8'h00 : device_event_status_one_r)
                                   | i_dev_event_one;
      status_byte_r <= status_byte_now;
      // output queue is never touched here on either link
      clear_status_r <= do_clear;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      resp_valid_r <= 1'b0;
      resp_data_r <= 8'h00;
      resp_text_r <= 1'b0;
    end
    else if (state_r == ST_RESPOND && i_resp_ready)
      resp_valid_r <= 1'b0;
    else if (take)
    begin
      resp_text_r <= 1'b0;
      resp_valid_r <= (state_nxt == ST_RESPOND);
      case (code_in)
        CMD_EVT_ENABLE_Q: resp_data_r <= event_enable_mask_r;
        CMD_EVT_STATUS_Q: resp_data_r <= esr_read;
        CMD_SRQ_ENABLE_Q: resp_data_r <= srq_enable_r;
        CMD_STATUS_BYTE_Q: resp_data_r <= status_byte_now;
        default: resp_data_r <= resp_data_r;
      endcase
    end
    else if (prior_done && code_r == CMD_OP_COMPLETE_Q)
    begin
      resp_valid_r <= 1'b1;
      resp_data_r <= ASCII_ONE;
      resp_text_r <= 1'b1;
    end
    else if (state_r == ST_TEST && st.done)
    begin
      resp_valid_r <= 1'b1;
      resp_data_r <= {5'h00, st.result};
      resp_text_r <= 1'b0;
    end
  end

  assign o_resp_valid = resp_valid_r;
  assign o_resp_data = resp_data_r;
  assign o_resp_text = resp_text_r;
  assign o_event_status = esr_read;
  assign o_status_byte = status_byte_r;
  assign o_clear_status = clear_status_r;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);

  property p_opc_after_prior;
    // an outside set pulse on bit 0 is a legal source and is excluded here
    $rose(event_status_latch_r[BIT_OP_COMPLETE]) && !$past(i_event_set[BIT_OP_COMPLETE])
      |-> $past(state_r == ST_WAIT_PRIOR && !i_prior_busy && code_r == CMD_OP_COMPLETE);
  endproperty
  a_opc_after_prior: assert property (p_opc_after_prior) else $error("opc bit set too early");

  property p_opc_query_one;
    $rose(o_resp_valid) && o_resp_text |-> o_resp_data == ASCII_ONE && $past(!i_prior_busy);
  endproperty
  a_opc_query_one: assert property (p_opc_query_one) else $error("opc query answer wrong");

  property p_hold_while_busy;
    state_r == ST_WAIT_PRIOR && i_prior_busy |-> !o_cmd_ready ##1 state_r == ST_WAIT_PRIOR;
  endproperty
  a_hold_while_busy: assert property (p_hold_while_busy) else $error("command taken while busy");

  property p_wait_no_effect;
    prior_done && code_r == CMD_WAIT |=> state_r == ST_IDLE && !o_resp_valid;
  endproperty
  a_wait_no_effect: assert property (p_wait_no_effect) else $error("wait had an effect");

  property p_clear_all;
    do_clear |=> (event_status_latch_r & ~$past(set_gated)) == 8'h00
      && (device_event_status_zero_r & ~$past(i_dev_event_zero)) == 8'h00
      && (device_event_status_one_r & ~$past(i_dev_event_one)) == 8'h00;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("clear status incomplete");

  property p_clear_keeps_masks;
    do_clear |=> $stable(event_enable_mask_r) && $stable(srq_enable_r) && o_clear_status;
  endproperty
  a_clear_keeps_masks: assert property (p_clear_keeps_masks) else $error("masks changed");

  property p_enable_write;
    take && code_in == CMD_EVT_ENABLE_W |=> event_enable_mask_r == $past(i_cmd_arg);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable mask not loaded");

  property p_status_read_clear;
    do_read_clear |=> o_resp_valid && o_resp_data == $past(esr_read)
      && (event_status_latch_r & ~$past(set_gated)) == 8'h00;
  endproperty
  a_status_read_clear: assert property (p_status_read_clear) else $error("status read wrong");

  property p_serial_bits_zero;
    !i_link_gpib |-> (o_event_status & SERIAL_UNUSED_MASK) == 8'h00;
  endproperty
  a_serial_bits_zero: assert property (p_serial_bits_zero) else $error("serial bits set");

  property p_srq_ignored_bits;
    (srq_enable_r & ~SRQ_WRITABLE_MASK) == 8'h00;
  endproperty
  a_srq_ignored_bits: assert property (p_srq_ignored_bits) else $error("ignored bit stored");

  property p_summary_bits;
    ##1 o_status_byte[STB_EVENT_SUMMARY] == $past(|(event_status_latch_r & event_enable_mask_r))
      && o_status_byte[STB_MESSAGE_AVAIL] == $past(i_msg_available);
  endproperty
  a_summary_bits: assert property (p_summary_bits) else $error("summary bit wrong");

endmodule
`default_nettype wire

//--- logic/status_sync_pkg.sv
// constants and types shared by the status and synchronisation command block
package status_sync_pkg;

  localparam int CLK_PERIOD_NS = 5;
  localparam int SELF_TEST_TIME_NS = 2000;
  localparam int SELF_TEST_CYCLES = (SELF_TEST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_SELF_TEST_Q = 4'h1,
    CMD_OP_COMPLETE = 4'h2,
    CMD_OP_COMPLETE_Q = 4'h3,
    CMD_WAIT = 4'h4,
    CMD_CLEAR_STATUS = 4'h5,
    CMD_EVT_ENABLE_W = 4'h6,
    CMD_EVT_ENABLE_Q = 4'h7,
    CMD_EVT_STATUS_Q = 4'h8,
    CMD_SRQ_ENABLE_W = 4'h9,
    CMD_SRQ_ENABLE_Q = 4'hA,
    CMD_STATUS_BYTE_Q = 4'hB
  } cmd_code_t;

  // event status latch and enable mask bit positions
  localparam int BIT_POWER_ON = 7;
  localparam int BIT_USER_REQUEST = 6;
  localparam int BIT_COMMAND_ERROR = 5;
  localparam int BIT_EXECUTION_ERROR = 4;
  localparam int BIT_DEVICE_DEP_ERROR = 3;
  localparam int BIT_QUERY_ERROR = 2;
  localparam int BIT_REQUEST_CONTROL = 1;
  localparam int BIT_OP_COMPLETE = 0;

  // status byte bit positions
  localparam int STB_MASTER_SUMMARY = 6;
  localparam int STB_EVENT_SUMMARY = 5;
  localparam int STB_MESSAGE_AVAIL = 4;
  localparam int STB_DEV_SUMMARY_ONE = 1;
  localparam int STB_DEV_SUMMARY_ZERO = 0;

  // self-test result bit positions
  localparam int TST_PROGRAM_MEM = 0;
  localparam int TST_WORK_RAM = 1;
  localparam int TST_NONVOL_MEM = 2;

  localparam logic [7:0] EVT_STATUS_RESET = 8'h80;
  localparam logic [7:0] EVT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] SRQ_ENABLE_RESET = 8'h00;
  localparam logic [7:0] SERIAL_UNUSED_MASK = 8'h43;
  localparam logic [7:0] SRQ_WRITABLE_MASK = 8'h33;
  localparam logic [7:0] ASCII_ONE = 8'h31;

endpackage

//--- testbench/common_status_sync_commands_bench.sv
// self-checking bench for the status and synchronisation command interpreter
`timescale 1ns/1ps
`default_nettype none
module common_status_sync_commands_bench
  import status_sync_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_rstn, i_link_gpib, i_prior_busy, i_msg_available;
  logic i_fault_program_mem, i_fault_work_ram, i_fault_nonvol_mem;
  logic i_cmd_valid, o_cmd_ready, o_resp_valid, i_resp_ready;
  logic [3:0] i_cmd_code;
  logic [7:0] i_cmd_arg, o_resp_data, i_event_set, i_dev_event_zero, i_dev_event_one;
  logic [7:0] o_event_status, o_status_byte;
  logic o_resp_text, o_clear_status, last_text;
  logic [15:0] lfsr = 16'hB465;
  int n_mismatch = 0;
  int n_compared = 0;

  always #2.5 i_clk_sys = ~i_clk_sys;

  status_sync_commands #(.TEST_CYCLES(3)) status_sync_commands_i (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_link_gpib(i_link_gpib),
    .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_cmd_arg(i_cmd_arg),
    .o_cmd_ready(o_cmd_ready), .i_prior_busy(i_prior_busy), .o_resp_valid(o_resp_valid),
    .o_resp_data(o_resp_data), .o_resp_text(o_resp_text), .i_resp_ready(i_resp_ready),
    .i_event_set(i_event_set), .i_dev_event_zero(i_dev_event_zero),
    .i_dev_event_one(i_dev_event_one), .i_msg_available(i_msg_available),
    .i_fault_program_mem(i_fault_program_mem), .i_fault_work_ram(i_fault_work_ram),
    .i_fault_nonvol_mem(i_fault_nonvol_mem), .o_event_status(o_event_status),
    .o_status_byte(o_status_byte), .o_clear_status(o_clear_status));

  host_model host_model_i (
    .i_clk_sys(i_clk_sys), .i_cmd_ready(o_cmd_ready), .i_resp_valid(o_resp_valid),
    .i_resp_data(o_resp_data), .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code),
    .o_cmd_arg(i_cmd_arg), .o_resp_ready(i_resp_ready));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [7:0] exp_evt(input logic [7:0] v, input logic g);
    return g ? v : (v & ~SERIAL_UNUSED_MASK);
  endfunction

  // srq enable holds the writable mask after an all-ones write
  function automatic logic [7:0] exp_stb(input logic [7:0] lat, input logic [7:0] msk,
                                         input logic message_available_bit, input logic [7:0] dz,
                                         input logic [7:0] d1);
    logic [7:0] s;
    s = 8'h00;
    s[STB_EVENT_SUMMARY] = |(lat & msk);
    s[STB_MESSAGE_AVAIL] = message_available_bit;
    s[STB_DEV_SUMMARY_ONE] = |d1;
    s[STB_DEV_SUMMARY_ZERO] = |dz;
    s[STB_MASTER_SUMMARY] = |(s & SRQ_WRITABLE_MASK);
    return s;
  endfunction

  task automatic rnd(output logic [7:0] v);
    lfsr = lfsr_next(lfsr);
    v = lfsr[7:0];
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic q(input logic [3:0] code, output logic [7:0] d);
    logic [7:0] s;
    rnd(s);
    host_model_i.query(code, int'(s[1:0]), d);
    // text flag stands until the next command is taken
    last_text = o_resp_text;
  endtask

  task automatic pulse(input logic [7:0] ev, input logic [7:0] dz, input logic [7:0] d1);
    @(posedge i_clk_sys);
    i_event_set <= ev;
    i_dev_event_zero <= dz;
    i_dev_event_one <= d1;
    @(posedge i_clk_sys);
    i_event_set <= 8'h00;
    i_dev_event_zero <= 8'h00;
    i_dev_event_one <= 8'h00;
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge i_clk_sys);
    n_mismatch++;
    test_done();
  end

  initial
  begin
    logic [7:0] d, ev, msk, dz, d1;
    logic message_available_bit, g, w;
    i_rstn = 1'b0;
    i_link_gpib = 1'b1;
    i_prior_busy = 1'b0;
    i_msg_available = 1'b0;
    i_event_set = 8'h00;
    i_dev_event_zero = 8'h00;
    i_dev_event_one = 8'h00;
    i_fault_program_mem = 1'b0;
    i_fault_work_ram = 1'b0;
    i_fault_nonvol_mem = 1'b0;
    repeat (12) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    q(CMD_EVT_ENABLE_Q, d);
    cmp(d, 8'h00);
    q(CMD_EVT_STATUS_Q, d);
    cmp(d, 8'h80);
    q(CMD_EVT_STATUS_Q, d);
    cmp(d, 8'h00);
    host_model_i.send(CMD_SRQ_ENABLE_W, 8'hFF);
    q(CMD_SRQ_ENABLE_Q, d);
    cmp(d, SRQ_WRITABLE_MASK);
    // undefined codes are taken and flag a command error
    host_model_i.send(4'hC, 8'h00);
    q(CMD_EVT_STATUS_Q, d);
    cmp(d, 8'h01 << BIT_COMMAND_ERROR);
    $display("test reset values done");
    for (int i = 0; i < 12; i++)
    begin
      rnd(msk);
      rnd(ev);
      rnd(dz);
      rnd(d1);
      // corner masks first, then random ones
      if (i < 2)
        msk = i == 0 ? 8'hFF : 8'h00;
      message_available_bit = lfsr[8];
      g = lfsr[9];
      i_link_gpib <= g;
      i_msg_available <= message_available_bit;
      host_model_i.send(CMD_EVT_ENABLE_W, msk);
      pulse(ev, dz, d1);
      q(CMD_STATUS_BYTE_Q, d);
      cmp(d, exp_stb(exp_evt(ev, g), msk, message_available_bit, dz, d1));
      cmp({7'h00, last_text}, 8'h00);
      @(negedge i_clk_sys);
      cmp(o_status_byte, exp_stb(exp_evt(ev, g), msk, message_available_bit, dz, d1));
      q(CMD_EVT_ENABLE_Q, d);
      cmp(d, msk);
      q(CMD_EVT_STATUS_Q, d);
      cmp(d, exp_evt(ev, g));
      q(CMD_EVT_STATUS_Q, d);
      cmp(d, 8'h00);
      pulse(ev, dz, d1);
      host_model_i.send(CMD_CLEAR_STATUS, 8'h00);
      @(negedge i_clk_sys);
      cmp({7'h00, o_clear_status}, 8'h01);
      @(negedge i_clk_sys);
      cmp({7'h00, o_clear_status}, 8'h00);
      q(CMD_STATUS_BYTE_Q, d);
      cmp(d, exp_stb(8'h00, msk, message_available_bit, 8'h00, 8'h00));
      q(CMD_EVT_ENABLE_Q, d);
      cmp(d, msk);
      q(CMD_EVT_STATUS_Q, d);
      cmp(d, 8'h00);
    end
    $display("test event latch and clear done");
    for (int i = 0; i < 8; i++)
    begin
      i_fault_program_mem <= i[0];
      i_fault_work_ram <= i[1];
      i_fault_nonvol_mem <= i[2];
      // host reads the result before trusting measurements
      q(CMD_SELF_TEST_Q, d);
      cmp(d, 8'(i));
      if (i == 0)
        cmp(d, 8'h00);
    end
    $display("test self-test done");
    for (int k = 0; k < 4; k++)
    begin
      g = k[0];
      w = k[1];
      i_link_gpib <= g;
      i_prior_busy <= 1'b1;
      host_model_i.send(w ? CMD_WAIT : CMD_OP_COMPLETE, 8'h00);
      repeat (6) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      cmp({7'h00, o_event_status[0]}, 8'h00);
      cmp({7'h00, o_cmd_ready}, 8'h00);
      @(posedge i_clk_sys);
      i_prior_busy <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      cmp({7'h00, o_event_status[0]}, {7'h00, g & ~w});
      q(CMD_EVT_STATUS_Q, d);
      cmp(d, {7'h00, g & ~w});
    end
    $display("test complete and wait done");
    @(posedge i_clk_sys);
    i_prior_busy <= 1'b1;
    fork
      q(CMD_OP_COMPLETE_Q, d);
      begin
        repeat (8) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        cmp({7'h00, o_resp_valid}, 8'h00);
        @(posedge i_clk_sys);
        i_prior_busy <= 1'b0;
      end
    join
    cmp(d, ASCII_ONE);
    cmp({7'h00, last_text}, 8'h01);
    $display("test complete query done");
    test_done();
  end
endmodule
`default_nettype wire

//--- testbench/host_model.sv
// host controller model issuing commands and collecting responses
`timescale 1ns/1ps
`default_nettype none
module host_model
  import status_sync_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_cmd_ready,
  input wire logic i_resp_valid,
  input wire logic [7:0] i_resp_data,
  output logic o_cmd_valid,
  output logic [3:0] o_cmd_code,
  output logic [7:0] o_cmd_arg,
  output logic o_resp_ready
);
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 4'h0;
    o_cmd_arg = 8'hA5;
    o_resp_ready = 1'b0;
  end

  // request stays up until the edge that samples ready high
  // no local limit: the bench watchdog turns a hang into a failure
  task automatic send(input logic [3:0] code, input logic [7:0] arg);
    @(posedge i_clk_sys);
    o_cmd_valid <= 1'b1;
    o_cmd_code <= code;
    o_cmd_arg <= arg;
    do
    begin
      @(posedge i_clk_sys);
    end while (i_cmd_ready !== 1'b1);
    o_cmd_valid <= 1'b0;
    o_cmd_code <= 4'h0;
    // released argument shows the inverse, never the stale value
    o_cmd_arg <= ~arg;
  endtask

  // stall sets how slowly the host takes the answer
  task automatic query(input logic [3:0] code, input int stall, output logic [7:0] data);
    send(code, 8'h00);
    while (i_resp_valid !== 1'b1)
    begin
      @(posedge i_clk_sys);
    end
    repeat (stall) @(posedge i_clk_sys);
    o_resp_ready <= 1'b1;
    @(posedge i_clk_sys);
    data = i_resp_data;
    o_resp_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire
